// file: logic/image_decoder_consts.svh
`ifndef IMAGE_DECODER_CONSTS_SVH
`define IMAGE_DECODER_CONSTS_SVH

// ---------------------------------------------------------------
// Image forms
// ---------------------------------------------------------------
`define INST_FULL        8'h78
`define INST_REDUCED     8'h79
`define LEN_MAX_FULL     9'h107
`define LEN_MAX_REDUCED  9'h106
`define LEN_MIN          9'h001
`define LEN_RESET        9'h001
`define REDUCED_SHIFT    9'h001

// ---------------------------------------------------------------
// Offsets within the full image
// ---------------------------------------------------------------
`define OFS_CTL          9'h000
`define OFS_IO           9'h001
`define OFS_FRAG_NO      9'h002
`define OFS_FRAG_REM     9'h003
`define OFS_FRAG_SIZE    9'h004
`define OFS_FLAGS        9'h005
`define OFS_LEN_LO       9'h006
`define OFS_LEN_HI       9'h007
`define OFS_DATA         9'h008
`define OFS_LAST         9'h1FF

// ---------------------------------------------------------------
// Bit positions
// ---------------------------------------------------------------
`define BIT_ACT          0
`define BIT_DACK         1
`define BIT_DRST         2
`define BIT_EACK         3
`define BIT_STBY         4
`define BIT_SW1          0
`define BIT_RST1         1
`define BIT_SW2          2
`define BIT_RST2         3
`define BIT_NEW_DATA     0
`define BIT_NEW_ENTRY    1

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define REG_CTRL         12'h000
`define REG_LEN          12'h004
`define REG_FRAG         12'h008
`define REG_ENTLEN       12'h00C
`define REG_DATA         12'h010
`define REG_STAT         12'h014
`define CTRL_INST_LSB    0
`define CTRL_HOST_LSB    8
`define DATA_VALID_BIT   8

`define FIFO_DEPTH       16
`define FIFO_WIDTH       8

`endif

// file: logic/image_decoder_pkg.sv
package image_decoder_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HDR  = 2'b01,
		ST_DATA = 2'b11,
		ST_SKIP = 2'b10
	} dec_state_t;

	typedef logic [8:0] img_ofs_t;

endpackage

// file: logic/byte_fifo_if.sv
`timescale 1ns/100ps

interface byte_fifo_if #(parameter int WIDTH = 8, parameter int DEPTH = 16);
	logic                     push_valid;
	logic                     push_ready;
	logic [WIDTH-1:0]         push_data;
	logic                     pop_valid;
	logic                     pop_ready;
	logic [WIDTH-1:0]         pop_data;
	logic [$clog2(DEPTH):0]   count;

	modport producer (output push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data, count);
	modport store (input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data, count);
endinterface

// file: logic/byte_fifo.sv
`timescale 1ns/100ps

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic core_clk_in,
	input  wire logic sys_rst_in,
	// Storage side
	byte_fifo_if.store f
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             do_push;
	logic             do_pop;

	assign do_push = f.push_valid && (count < (AW+1)'(DEPTH));
	assign do_pop  = f.pop_ready && (count != '0);
	assign f.pop_valid = (count != '0);
	assign f.pop_data  = mem[rd_ptr];
	// One slot of headroom covers the producer's registered ready
	assign f.push_ready = (count < (AW+1)'(DEPTH - 1));
	assign f.count = count;

	always_ff @(posedge core_clk_in)
	begin
		if (do_push)
			mem[wr_ptr] <= f.push_data;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	fifo_bound_a: assert property (count <= (AW+1)'(DEPTH))
		else $error("fifo count beyond depth");
	fifo_nofill_a: assert property (
		(count == (AW+1)'(DEPTH) && !do_pop) |=> count == (AW+1)'(DEPTH))
		else $error("fifo lost a word while full");

endmodule // byte_fifo

// file: logic/image_decoder.sv
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/100ps
`include "image_decoder_consts.svh"

// Contract
// - Full form is instance 120, length 1 to 263 bytes.
// - Reduced form is instance 121, no I/O byte, length 1 to 262.
// - Full image entry data starts at offset 8; length is 8 plus data.
// - Reduced image entry data starts at offset 7; fields at 1 to 6.
// - One-byte image decodes only control bits of byte zero.
// - Two-byte full image also decodes I/O monitoring byte one.
// - Switching output follows activation bit only when host-driven.
// - Toggle flags act on any change of value, never on level.
module cyclic_output_image_decoder
	import image_decoder_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        sys_rst_in,
	// APB slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Cyclic image byte stream
	input  wire logic [7:0]  img_byte_in,
	input  wire logic        img_valid_in,
	input  wire logic        img_first_in,
	output logic             img_ready_out,
	// Decoded control
	output logic             activation_out,
	output logic             data_ack_out,
	output logic             data_reset_out,
	output logic             error_ack_out,
	output logic             standby_out,
	output logic [1:0]       switch_out,
	output logic [1:0]       event_reset_out,
	output logic             new_data_out,
	output logic             new_entry_pulse_out
);

	byte_fifo_if #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) fq ();

	byte_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.f           (fq.store)
	);

	function automatic img_ofs_t norm_ofs(img_ofs_t ofs, logic reduced);
		if (reduced && ofs != `OFS_CTL)
			return img_ofs_t'(ofs + `REDUCED_SHIFT);
		return ofs;
	endfunction

	logic       reduced;
	img_ofs_t   cfg_len;
	logic [1:0] host_drive;
	img_ofs_t   ofs;
	dec_state_t state;
	dec_state_t next_state;
	logic [1:0] io_act;
	logic [7:0] frag_no;
	logic [7:0] frag_rem;
	logic [7:0] frag_size;
	logic [15:0] entry_len;
	logic       entry_toggle;
	logic       accept;
	img_ofs_t   byte_ofs;
	img_ofs_t   norm;
	logic       in_image;
	logic       apb_setup;
	logic       apb_done;

	// ---------------------------------------------------------------
	// Stream position
	// ---------------------------------------------------------------
	assign accept   = img_valid_in && img_ready_out;
	assign byte_ofs = img_first_in ? `OFS_CTL : ofs;
	assign in_image = (byte_ofs < cfg_len) &&
		(img_first_in || state != ST_IDLE);
	assign norm     = norm_ofs(byte_ofs, reduced);

	always_comb
	begin
		next_state = state;
		if (accept && in_image)
			next_state = (norm >= `OFS_DATA) ? ST_DATA : ST_HDR;
		else if (accept && !in_image && state != ST_IDLE)
			next_state = ST_SKIP;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			ofs   <= `OFS_CTL;
			state <= ST_IDLE;
		end
		else if (accept)
		begin
			state <= next_state;
			if (byte_ofs != `OFS_LAST)
				ofs <= img_ofs_t'(byte_ofs + 9'h001);
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			img_ready_out <= 1'b0;
		else
			img_ready_out <= fq.push_ready;
	end

	// ---------------------------------------------------------------
	// Field decode
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			activation_out <= 1'b0;
			data_ack_out   <= 1'b0;
			data_reset_out <= 1'b0;
			error_ack_out  <= 1'b0;
			standby_out    <= 1'b0;
		end
		else if (accept && in_image && norm == `OFS_CTL)
		begin
			activation_out <= img_byte_in[`BIT_ACT];
			data_ack_out   <= img_byte_in[`BIT_DACK];
			data_reset_out <= img_byte_in[`BIT_DRST];
			error_ack_out  <= img_byte_in[`BIT_EACK];
			standby_out    <= img_byte_in[`BIT_STBY];
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			io_act          <= 2'h0;
			event_reset_out <= 2'h0;
		end
		else if (accept && in_image && norm == `OFS_IO)
		begin
			io_act          <= {img_byte_in[`BIT_SW2], img_byte_in[`BIT_SW1]};
			event_reset_out <= {img_byte_in[`BIT_RST2],
				img_byte_in[`BIT_RST1]};
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			switch_out <= 2'h0;
		else
			switch_out <= io_act & host_drive;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			frag_no   <= 8'h00;
			frag_rem  <= 8'h00;
			frag_size <= 8'h00;
			entry_len <= 16'h0000;
		end
		else if (accept && in_image)
		begin
			unique case (norm)
				`OFS_FRAG_NO:   frag_no   <= img_byte_in;
				`OFS_FRAG_REM:  frag_rem  <= img_byte_in;
				`OFS_FRAG_SIZE: frag_size <= img_byte_in;
				`OFS_LEN_LO:    entry_len[7:0]  <= img_byte_in;
				`OFS_LEN_HI:    entry_len[15:8] <= img_byte_in;
				default:        ;
			endcase
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			new_data_out        <= 1'b0;
			entry_toggle        <= 1'b0;
			new_entry_pulse_out <= 1'b0;
		end
		else
		begin
			new_entry_pulse_out <= 1'b0;
			if (accept && in_image && norm == `OFS_FLAGS)
			begin
				new_data_out <= img_byte_in[`BIT_NEW_DATA];
				entry_toggle <= img_byte_in[`BIT_NEW_ENTRY];
				new_entry_pulse_out <=
					img_byte_in[`BIT_NEW_ENTRY] != entry_toggle;
			end
		end
	end

	assign fq.push_valid = accept && in_image && norm >= `OFS_DATA;
	assign fq.push_data  = img_byte_in;

	// ---------------------------------------------------------------
	// APB registers
	// ---------------------------------------------------------------
	assign apb_setup   = psel_in && !penable_in;
	assign apb_done    = psel_in && penable_in && pready_out;
	assign fq.pop_ready = apb_done && !pwrite_in && paddr_in == `REG_DATA;

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			reduced    <= 1'b0;
			cfg_len    <= `LEN_RESET;
			host_drive <= 2'h0;
		end
		else if (apb_done && pwrite_in)
		begin
			if (paddr_in == `REG_CTRL)
			begin
				if (pwdata_in[`CTRL_INST_LSB +: 8] == `INST_FULL)
					reduced <= 1'b0;
				else if (pwdata_in[`CTRL_INST_LSB +: 8] == `INST_REDUCED)
				begin
					reduced <= 1'b1;
					if (cfg_len > `LEN_MAX_REDUCED)
						cfg_len <= `LEN_MAX_REDUCED;
				end
				host_drive <= pwdata_in[`CTRL_HOST_LSB +: 2];
			end
			if (paddr_in == `REG_LEN && pwdata_in[8:0] >= `LEN_MIN &&
				pwdata_in[8:0] <= (reduced ? `LEN_MAX_REDUCED
				: `LEN_MAX_FULL) && pwdata_in[31:9] == 23'h0)
				cfg_len <= pwdata_in[8:0];
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
		end
		else if (apb_setup)
		begin
			pready_out  <= 1'b1;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
			unique case (paddr_in)
				`REG_CTRL:   prdata_out <= {22'h0, host_drive,
					reduced ? `INST_REDUCED : `INST_FULL};
				`REG_LEN:    prdata_out <= {23'h0, cfg_len};
				`REG_FRAG:   prdata_out <= {7'h0, new_data_out,
					frag_size, frag_rem, frag_no};
				`REG_ENTLEN: prdata_out <= {16'h0, entry_len};
				`REG_DATA:   prdata_out <= {23'h0, fq.pop_valid,
					fq.pop_data};
				`REG_STAT:   prdata_out <= {11'h0, fq.count, 2'h0,
					event_reset_out, switch_out, io_act, 3'h0,
					standby_out, error_ack_out, data_reset_out,
					data_ack_out, activation_out};
				default:     pslverr_out <= 1'b1;
			endcase
		end
		else
		begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	len_range_a: assert property (cfg_len >= `LEN_MIN &&
		cfg_len <= `LEN_MAX_FULL)
		else $error("configured length out of range");
	len_reduced_a: assert property (reduced |->
		cfg_len <= `LEN_MAX_REDUCED)
		else $error("reduced form length check failed");
	entry_start_a: assert property (fq.push_valid |->
		norm >= `OFS_DATA && byte_ofs < cfg_len)
		else $error("entry byte pushed outside data area");
	reduced_data_a: assert property ((accept && reduced &&
		byte_ofs == (`OFS_DATA - `REDUCED_SHIFT) && in_image) |->
		fq.push_valid)
		else $error("reduced data byte 7 not taken");
	single_byte_a: assert property (cfg_len == `LEN_MIN |->
		!fq.push_valid && (!accept || img_first_in || !in_image))
		else $error("single byte image decoded beyond byte zero");
	io_byte_a: assert property ((accept && in_image && !reduced &&
		byte_ofs == `OFS_IO) |=> io_act ==
		{$past(img_byte_in[`BIT_SW2]), $past(img_byte_in[`BIT_SW1])})
		else $error("I/O byte not decoded");
	host_gate_a: assert property (##1 (switch_out ==
		($past(io_act) & $past(host_drive))))
		else $error("switching output not gated by host drive");
	toggle_edge_a: assert property ((accept && in_image &&
		norm == `OFS_FLAGS && img_byte_in[`BIT_NEW_ENTRY] != entry_toggle)
		|=> new_entry_pulse_out ##1 !new_entry_pulse_out)
		else $error("new entry toggle not seen as one pulse");
	ctl_bits_a: assert property ((accept && in_image &&
		byte_ofs == `OFS_CTL) |=> activation_out ==
		$past(img_byte_in[`BIT_ACT]) && standby_out ==
		$past(img_byte_in[`BIT_STBY]))
		else $error("control byte not decoded");
	len_order_a: assert property ((accept && in_image &&
		norm == `OFS_LEN_LO) |=> entry_len[7:0] == $past(img_byte_in))
		else $error("entry length low byte misplaced");

endmodule // cyclic_output_image_decoder

// file: verification/image_source.sv
`timescale 1ns/100ps

// ---------------------------------------------------------
// Controller side of the cyclic connection
// ---------------------------------------------------------
module image_source (
	// Clock
	input  wire logic       clk_in,
	// Byte stream
	input  wire logic       ready_in,
	output logic      [7:0] byte_out,
	output logic            valid_out,
	output logic            first_out
);
	int gap;

	initial
	begin
		gap = 0;
		byte_out = 8'h00;
		valid_out = 1'b0;
		first_out = 1'b0;
	end

	task send(input logic [7:0] img[$]);
		for (int i = 0; i < img.size(); i++)
		begin
			repeat (gap + 1) @(posedge clk_in);
			byte_out  <= img[i];
			valid_out <= 1'b1;
			first_out <= (i == 0);
			do
				@(posedge clk_in);
			while (ready_in !== 1'b1);
			valid_out <= 1'b0;
			first_out <= 1'b0;
			byte_out  <= ~img[i];
		end
	endtask
endmodule // image_source

// file: verification/cyclic_output_image_decoder_test.sv
`timescale 1ns/100ps
`include "image_decoder_consts.svh"

module cyclic_output_image_decoder_test
	import image_decoder_pkg::*;
;
	logic        core_clk;
	logic        sys_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  img_byte;
	logic        img_valid;
	logic        img_first;
	logic        img_ready;
	logic [4:0]  ctl;
	logic [1:0]  sw;
	logic [1:0]  evr;
	logic        new_data;
	logic        pulse;
	logic        perr;
	logic [31:0] r;
	int          fail_count;
	int          checks;
	int          pulses;

	cyclic_output_image_decoder u_cyclic_output_image_decoder (
		.core_clk_in(core_clk),
		.sys_rst_in(sys_rst),
		.psel_in(psel),
		.penable_in(penable),
		.pwrite_in(pwrite),
		.paddr_in(paddr),
		.pwdata_in(pwdata),
		.prdata_out(prdata),
		.pready_out(pready),
		.pslverr_out(pslverr),
		.img_byte_in(img_byte),
		.img_valid_in(img_valid),
		.img_first_in(img_first),
		.img_ready_out(img_ready),
		.activation_out(ctl[0]),
		.data_ack_out(ctl[1]),
		.data_reset_out(ctl[2]),
		.error_ack_out(ctl[3]),
		.standby_out(ctl[4]),
		.switch_out(sw),
		.event_reset_out(evr),
		.new_data_out(new_data),
		.new_entry_pulse_out(pulse)
	);

	image_source u_image_source (
		.clk_in(core_clk),
		.ready_in(img_ready),
		.byte_out(img_byte),
		.valid_out(img_valid),
		.first_out(img_first)
	);

	initial
		core_clk = 1'b0;
	always #50 core_clk = ~core_clk;

	always @(posedge core_clk)
		if (pulse === 1'b1)
			pulses++;

	// ---------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------
	task complete_run;
		$display("Mismatches %0d, checks %0d", fail_count, checks);
		if (fail_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk_reg(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask

	task chk_pin(input string n, input logic [7:0] g,
		input logic [7:0] e);
		checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		r = prdata;
		perr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk_reg(nm, e, r);
	endtask

	task wr_rd(input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] e);
		apb(1'b1, a, d);
		rd(a, e, "readback");
	endtask

	task frame(input logic f, input logic [7:0] c, io, fno, rem, fsz,
		flg, input int n);
		logic [7:0] q[$];
		q = {c};
		if (f)
			q = {q, io};
		q = {q, fno, rem, fsz, flg, n[7:0], 8'h00};
		for (int i = 0; i < n; i++)
			q = {q, 8'hA0 + i[7:0]};
		u_image_source.send(q);
		repeat (3) @(posedge core_clk);
	endtask

	task drain(input int s, input int n, input logic e);
		for (int i = s; i < s + n; i++)
			rd(`REG_DATA, 32'h100 | (32'hA0 + i), "entry byte");
		if (e)
		begin
			apb(1'b0, `REG_DATA, 32'h0);
			chk_pin("empty", {7'h00, r[8]}, 8'h00);
		end
	endtask

	// ---------------------------------------------------------
	// Tests
	// ---------------------------------------------------------
	initial
	begin
		fail_count = 0;
		checks = 0;
		pulses = 0;
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(`REG_CTRL, 32'h78, "ctrl");
		rd(`REG_LEN, 32'h1, "len");
		frame(1, 8'hFF, 8'h0F, 8'h01, 8'h02, 8'h03, 8'h03, 4);
		rd(`REG_STAT, 32'h1F, "stat");
		chk_pin("ctl pins", {3'h0, ctl}, 8'h1F);
		rd(`REG_FRAG, 32'h0, "frag");
		chk_pin("pulses", pulses[7:0], 8'h00);
		apb(1'b1, `REG_CTRL, 32'h178);
		apb(1'b1, `REG_LEN, 32'h2);
		frame(1, 8'h00, 8'h07, 8'h01, 8'h02, 8'h03, 8'h03, 4);
		rd(`REG_STAT, 32'h1700, "stat");
		chk_pin("switch", {6'h0, sw}, 8'h01);
		chk_pin("event reset", {6'h0, evr}, 8'h01);
		apb(1'b1, `REG_CTRL, 32'h78);
		apb(1'b1, `REG_LEN, 32'd18);
		frame(1, 8'h01, 8'h00, 8'h03, 8'h02, 8'h0A, 8'h03, 10);
		rd(`REG_FRAG, 32'h010A0203, "frag");
		rd(`REG_ENTLEN, 32'hA, "entry len");
		rd(`REG_STAT, 32'h000A0001, "stat");
		chk_pin("new data", {7'h0, new_data}, 8'h01);
		chk_pin("pulses", pulses[7:0], 8'h01);
		drain(0, 10, 1'b1);
		apb(1'b1, `REG_CTRL, 32'h79);
		apb(1'b1, `REG_LEN, 32'd17);
		frame(0, 8'h10, 8'h00, 8'h05, 8'h00, 8'h0A, 8'h00, 10);
		rd(`REG_FRAG, 32'h000A0005, "frag");
		rd(`REG_STAT, 32'h000A0010, "stat");
		chk_pin("pulses", pulses[7:0], 8'h02);
		drain(0, 10, 1'b1);
		frame(0, 8'h10, 8'h00, 8'h05, 8'h00, 8'h0A, 8'h00, 0);
		chk_pin("pulses", pulses[7:0], 8'h02);
		wr_rd(`REG_LEN, 32'd263, 32'd17);
		wr_rd(`REG_LEN, 32'd262, 32'd262);
		wr_rd(`REG_CTRL, 32'h7A, 32'h79);
		wr_rd(`REG_CTRL, 32'h78, 32'h78);
		wr_rd(`REG_LEN, 32'd264, 32'd262);
		wr_rd(`REG_LEN, 32'd0, 32'd262);
		wr_rd(`REG_LEN, 32'd263, 32'd263);
		wr_rd(`REG_CTRL, 32'h79, 32'h79);
		rd(`REG_LEN, 32'd262, "len clamp");
		apb(1'b1, `REG_CTRL, 32'h78);
		apb(1'b0, 12'h018, 32'h0);
		chk_pin("slverr", {7'h0, perr}, 8'h01);
		apb(1'b1, `REG_LEN, 32'd28);
		u_image_source.gap = 2;
		fork
			frame(1, 8'h00, 8'h00, 8'h01, 8'h00, 8'h14, 8'h03, 20);
		join_none
		repeat (150) @(posedge core_clk);
		chk_pin("ready", {7'h0, img_ready}, 8'h00);
		rd(`REG_STAT, 32'h000F0000, "stat");
		drain(0, 8, 1'b0);
		wait fork;
		drain(8, 12, 1'b1);
		chk_pin("pulses", pulses[7:0], 8'h03);
		complete_run;
	end

	initial
	begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		$display("[ERR] watchdog exp done got hang");
		complete_run;
	end
endmodule // cyclic_output_image_decoder_test
